// file: pkg/status_byte_cfg.svh
// Constants for the status byte and service request block
// ****************************************************************
// ****************************************************************
`ifndef STATUS_BYTE_CFG_SVH
`define STATUS_BYTE_CFG_SVH

`define SB_WIDTH        8
`define SB_BIT_MEAS     0
`define SB_BIT_ERR      2
`define SB_BIT_QUES     3
`define SB_BIT_OUT      4
`define SB_BIT_STD_EVT  5
`define SB_BIT_SUMMARY  6
`define SB_BIT_OPER     7
`define SB_MASK_RESET   8'h00
`define SB_MASK_USED    8'hbf

`endif

// file: pkg/status_byte_pkg.sv
// Types shared by the status byte logic
package status_byte_pkg;
	typedef logic [7:0] sb_byte_t;
	typedef enum logic [1:0] {
		RD_IDLE,
		RD_QUERY,
		RD_POLL
	} sb_read_t;
endpackage

// file: logic/summary_gate.sv
// One lower status set summary: event bits gated by enable bits and ORed
module summary_gate #(
	parameter int WIDTH = 16
) (
	input  wire logic [WIDTH-1:0] event_bits,
	input  wire logic [WIDTH-1:0] enable_bits,
	output logic                  summary
);
	// A masked event cannot reach the status byte
	assign summary = |(event_bits & enable_bits);
endmodule // summary_gate

// file: logic/status_byte_srq.sv
// Status byte, service request mask, master summary and SRQ generation
`include "status_byte_cfg.svh"
module status_byte_srq
	import status_byte_pkg::*;
#(
	parameter int EV_WIDTH = 16
) (
	input  wire logic                clk_sys,
	input  wire logic                rst,
	// Lower register sets feeding bits 0, 3, 5 and 7
	input  wire logic [EV_WIDTH-1:0] meas_event,
	input  wire logic [EV_WIDTH-1:0] meas_enable,
	input  wire logic [EV_WIDTH-1:0] ques_event,
	input  wire logic [EV_WIDTH-1:0] ques_enable,
	input  wire logic [7:0]          std_event,
	input  wire logic [7:0]          std_enable,
	input  wire logic [EV_WIDTH-1:0] oper_event,
	input  wire logic [EV_WIDTH-1:0] oper_enable,
	// Queue occupancy levels
	input  wire logic                out_queue_not_empty,
	input  wire logic                err_queue_not_empty,
	// Command strobes from the command parser
	input  wire logic                clear_status,
	input  wire logic                mask_write,
	input  wire logic [7:0]          mask_wdata,
	input  wire logic                stb_query,
	input  wire logic                serial_poll,
	// Results
	output logic [7:0]               service_request_mask,
	output logic [7:0]               query_byte_ff,
	output logic                     query_valid_ff,
	output logic [7:0]               poll_byte_ff,
	output logic                     poll_valid_ff,
	output logic                     srq_out_n,
	output logic                     srq_oe_n,
	output logic                     master_summary_bit,
	output logic                     request_service_bit
);
	// ****************************************************************
	// Summary messages
	// ****************************************************************
	localparam sb_byte_t MASK_USED = `SB_MASK_USED;

	logic                meas_sum;
	logic                ques_sum;
	logic                oper_sum;
	logic                std_event_summary_bit;
	logic                output_pending_bit;
	logic                error_pending_bit;
	logic [EV_WIDTH-1:0] set_event [3];
	logic [EV_WIDTH-1:0] set_enable [3];
	logic [2:0]          set_sum;
	sb_byte_t            summary_byte;
	sb_byte_t            service_status_byte;
	sb_byte_t            poll_status_byte;
	sb_byte_t            enabled_bits;
	sb_byte_t            bit_rise;
	sb_byte_t            mask_ff;
	sb_byte_t            nxt_mask;
	sb_byte_t            prev_enabled_ff;
	sb_byte_t            nxt_prev_enabled;
	logic                request_ff;
	logic                nxt_request;
	logic                request_drop;
	logic                rise_seen;
	logic                out_hold_ff;
	logic                nxt_out_hold;

	// Wide lower sets share one gate shape: 0 measurement, 1 questionable, 2 operation
	assign set_event[0]  = meas_event;
	assign set_enable[0] = meas_enable;
	assign set_event[1]  = ques_event;
	assign set_enable[1] = ques_enable;
	assign set_event[2]  = oper_event;
	assign set_enable[2] = oper_enable;

	generate
		for (genvar g = 0; g < 3; g++) begin : g_set
			summary_gate #(.WIDTH(EV_WIDTH)) u_gate (
				.event_bits  (set_event[g]),
				.enable_bits (set_enable[g]),
				.summary     (set_sum[g])
			);
		end
	endgenerate

	assign meas_sum = set_sum[0];
	assign ques_sum = set_sum[1];
	assign oper_sum = set_sum[2];
	// Standard event register clears on its own read, so its summary drops too
	summary_gate #(.WIDTH(8)) u_std (
		.event_bits  (std_event),
		.enable_bits (std_enable),
		.summary     (std_event_summary_bit)
	);

	// Queue bits are plain levels of occupancy
	assign output_pending_bit = out_queue_not_empty;
	assign error_pending_bit  = err_queue_not_empty;

	// ****************************************************************
	// Status byte assembly
	// ****************************************************************
	// Summary bits are not latched; they track the sources directly, except bit 4, which is also gated by the registered out_hold_ff
	always_comb begin
		summary_byte = 8'h00;
		summary_byte[`SB_BIT_MEAS] = meas_sum;
		summary_byte[`SB_BIT_ERR]  = error_pending_bit;
		summary_byte[`SB_BIT_QUES] = ques_sum;
		summary_byte[`SB_BIT_OUT]  = output_pending_bit & out_hold_ff;
		summary_byte[`SB_BIT_STD_EVT] = std_event_summary_bit;
		summary_byte[`SB_BIT_OPER] = oper_sum;
	end

	// Per status bit: mask gating and a rising edge against the edge memory.
	// Bit 6 of the mask never participates; the summary slot is always zero anyway
	generate
		for (genvar b = 0; b < `SB_WIDTH; b++) begin : g_bit
			assign enabled_bits[b] = summary_byte[b] & mask_ff[b] & MASK_USED[b];
			assign bit_rise[b]     = enabled_bits[b] & ~prev_enabled_ff[b];
		end
	endgenerate

	// Master summary stays up while any enabled summary bit is up, polls or not
	assign master_summary_bit = |enabled_bits;
	assign rise_seen          = |bit_rise;

	// ****************************************************************
	// Service request enable mask
	// ****************************************************************
	// A write of zero naturally clears it; bit 6 is stored as zero
	assign nxt_mask = mask_write ? (mask_wdata & `SB_MASK_USED) : mask_ff;
	assign service_request_mask = mask_ff;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mask_ff <= `SB_MASK_RESET;
		end else begin
			mask_ff <= nxt_mask;
		end
	end

	// ****************************************************************
	// Request-for-service bit
	// ****************************************************************
	// Poll or clear-status wins over a same-cycle edge. After clear-status that
	// edge is consumed; after a poll the emptied memory lets it request again.
	assign request_drop = serial_poll | clear_status;
	assign nxt_request  = request_drop ? 1'b0 :
		(rise_seen ? 1'b1 : request_ff);

	// Edge memory resets after a poll so a standing event can request again
	assign nxt_prev_enabled = serial_poll ? 8'h00 : enabled_bits;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			request_ff      <= 1'b0;
			prev_enabled_ff <= 8'h00;
		end else begin
			request_ff      <= nxt_request;
			prev_enabled_ff <= nxt_prev_enabled;
		end
	end
	assign request_service_bit = request_ff;

	// ****************************************************************
	// Status byte images
	// ****************************************************************
	// Query image carries the master summary in bit 6, poll image the request
	assign service_status_byte = summary_byte | {1'b0, master_summary_bit, 6'h00};
	assign poll_status_byte    = summary_byte | {1'b0, request_ff, 6'h00};

	// ****************************************************************
	// Output-pending hold across clear-status
	// ****************************************************************
	// Clear-status hides output-pending until the queue next goes empty;
	// either behaviour is permitted, and showing matches power-up.
	assign nxt_out_hold = clear_status ? 1'b0 :
		(~out_queue_not_empty ? 1'b1 : out_hold_ff);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			out_hold_ff <= 1'b1;
		end else begin
			out_hold_ff <= nxt_out_hold;
		end
	end

	// ****************************************************************
	// Readout of the status byte
	// ****************************************************************
	// Query shows master summary in bit 6 and changes nothing
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			query_byte_ff  <= 8'h00;
			query_valid_ff <= 1'b0;
		end else begin
			query_valid_ff <= stb_query;
			if (stb_query) begin
				query_byte_ff <= service_status_byte;
			end
		end
	end

	// Poll shows the request bit as it stood before the poll clears it
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			poll_byte_ff  <= 8'h00;
			poll_valid_ff <= 1'b0;
		end else begin
			poll_valid_ff <= serial_poll;
			if (serial_poll) begin
				poll_byte_ff <= poll_status_byte;
			end
		end
	end

	// ****************************************************************
	// SRQ line
	// ****************************************************************
	// Open drain: pull low only while requesting, enable low means driving
	assign srq_out_n = 1'b0;
	assign srq_oe_n  = ~request_ff;
endmodule // status_byte_srq

// file: testbench/status_byte_srq_chk.sv
// Port checker for the status byte and service request block
module status_byte_srq_chk (
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic       stb_query,
	input wire logic       serial_poll,
	input wire logic       clear_status,
	input wire logic       mask_write,
	input wire logic [7:0] mask_wdata,
	input wire logic [7:0] query_byte_ff,
	input wire logic       query_valid_ff,
	input wire logic [7:0] poll_byte_ff,
	input wire logic       poll_valid_ff,
	input wire logic       srq_oe_n,
	input wire logic       master_summary_bit,
	input wire logic       request_service_bit,
	input wire logic [7:0] service_request_mask
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ****************
	// Assertions
	// ****************
	query_summary_a: assert property (stb_query |=> query_valid_ff
		&& query_byte_ff[6] == $past(master_summary_bit)) else $error("query bit 6 wrong");
	poll_request_a: assert property (serial_poll |=> poll_valid_ff
		&& poll_byte_ff[6] == $past(request_service_bit)) else $error("poll bit 6 wrong");
	poll_clear_a: assert property (serial_poll |=> !request_service_bit)
		else $error("poll left request set");
	srq_pin_a: assert property (srq_oe_n == !request_service_bit) else $error("srq pin wrong");
	mask_write_a: assert property (mask_write |=>
		service_request_mask == ($past(mask_wdata) & 8'hbf)) else $error("mask not stored");
	mask_bit6_a: assert property (!service_request_mask[6]) else $error("mask bit 6 set");
	masked_off_a: assert property (service_request_mask == 8'h00 |-> !master_summary_bit)
		else $error("masked summary set bit 6");
	rise_req_a: assert property ($rose(master_summary_bit) && !serial_poll
		&& !clear_status |=> request_service_bit) else $error("no request on rise");
	query_or_a: assert property (query_valid_ff |-> query_byte_ff[6] ==
		|(query_byte_ff & $past(service_request_mask) & 8'hbf)) else $error("query bit 6 not OR");
	repoll_request_a: assert property (serial_poll ##1 (master_summary_bit
		&& !serial_poll && !clear_status) |=> request_service_bit) else $error("no request after poll");
	// Main scenarios seen
	cover property (serial_poll && request_service_bit);
	cover property (stb_query && master_summary_bit);
	cover property (clear_status && request_service_bit);
endmodule // status_byte_srq_chk

bind status_byte_srq status_byte_srq_chk i_chk (.clk_sys, .rst, .stb_query, .serial_poll,
	.clear_status, .mask_write, .mask_wdata, .query_byte_ff, .query_valid_ff, .poll_byte_ff,
	.poll_valid_ff, .srq_oe_n, .master_summary_bit, .request_service_bit, .service_request_mask);

// file: testbench/gpib_ctrl_model.sv
// Bus controller model that sends common commands and serial polls as strobes
module gpib_ctrl_model (
	input  wire logic clk_sys,
	output logic      clear_status,
	output logic      mask_write,
	output logic [7:0] mask_wdata,
	output logic      stb_query,
	output logic      serial_poll
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {clear_status, mask_write, stb_query, serial_poll, mask_wdata} = '0;
	// One single-cycle command: 0 clear, 1 mask write, 2 query, 3 poll
	task automatic issue(input logic [1:0] op, input logic [7:0] val);
		@(posedge clk_sys);
		#5;
		mask_wdata = val;
		case (op)
			2'h0: clear_status = 1'b1;
			2'h1: mask_write = 1'b1;
			2'h2: stb_query = 1'b1;
			default: serial_poll = 1'b1;
		endcase
		@(posedge clk_sys);
		#5;
		{clear_status, mask_write, stb_query, serial_poll} = '0;
		mask_wdata = ~val; // Stale value is scrambled so nobody relies on it
	endtask
endmodule // gpib_ctrl_model

// file: testbench/status_byte_srq_tb.sv
// Self-checking bench for the status byte and service request block
module status_byte_srq_tb;
	import status_byte_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic [15:0] ev [4];
	logic [15:0] en [4];
	logic        out_q = 1'b0;
	logic        err_q = 1'b0;
	logic [7:0]  mask;
	wire         clear_status, mask_write, stb_query, serial_poll, qv, pv, oe_n, srq_n;
	wire         summary_bit, request_bit;
	wire [7:0]   mask_wdata, srm, qb, pb;
	sb_byte_t    q_exp[$];
	sb_byte_t    p_exp[$];
	int          num_errors = 0;
	int          n_checks = 0;
	int          seed = 32'ha7fe;
	always #25 clk_sys = ~clk_sys;
	gpib_ctrl_model i_ctl (.clk_sys, .clear_status, .mask_write, .mask_wdata, .stb_query,
		.serial_poll);
	status_byte_srq #(.EV_WIDTH(16)) i_dut (.clk_sys, .rst, .meas_event(ev[0]),
		.meas_enable(en[0]), .ques_event(ev[1]), .ques_enable(en[1]), .std_event(ev[2][7:0]),
		.std_enable(en[2][7:0]), .oper_event(ev[3]), .oper_enable(en[3]),
		.out_queue_not_empty(out_q), .err_queue_not_empty(err_q), .clear_status, .mask_write,
		.mask_wdata, .stb_query, .serial_poll, .service_request_mask(srm), .query_byte_ff(qb),
		.query_valid_ff(qv), .poll_byte_ff(pb), .poll_valid_ff(pv), .srq_out_n(srq_n),
		.srq_oe_n(oe_n), .master_summary_bit(summary_bit), .request_service_bit(request_bit));
	// Summary bits as the status byte should show them, bit 6 left clear
	function automatic sb_byte_t sum_byte();
		return {|(ev[3] & en[3]), 1'b0, |(ev[2][7:0] & en[2][7:0]), out_q,
			|(ev[1] & en[1]), err_q, 1'b0, |(ev[0] & en[0])};
	endfunction
	task automatic check(input sb_byte_t got, input sb_byte_t exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic check_bit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: level %b want %b", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Result watcher: oldest note against each byte as it appears
	always @(posedge clk_sys) begin
		#1;
		if (qv === 1'b1) check(qb, q_exp.size() ? q_exp.pop_front() : 8'hxx);
		if (pv === 1'b1) check(pb, p_exp.size() ? p_exp.pop_front() : 8'hxx);
	end
	initial begin
		for (int k = 0; k < 4; k++) {ev[k], en[k]} = '0;
		repeat (3) @(posedge clk_sys);
		#5 rst = 1'b0;
		check(srm, 8'h00);
		check_bit(oe_n, 1'b1);
		check_bit(srq_n, 1'b0);
		// Random summaries and masks, each read twice by query
		for (int i = 0; i < 12; i++) begin
			for (int k = 0; k < 4; k++) {ev[k], en[k]} = {16'($random(seed)), 16'($random(seed) >> i)};
			{out_q, err_q} = 2'($random(seed));
			mask = 8'($random(seed));
			i_ctl.issue(2'h1, mask);
			check(srm, mask & 8'hbf);
			repeat (2) q_exp.push_back(sum_byte() | {1'b0, |(sum_byte() & mask & 8'hbf), 6'h0});
			repeat (2) i_ctl.issue(2'h2, 8'h00);
		end
		i_ctl.issue(2'h0, 8'h00);
		check_bit(request_bit, 1'b0);
		for (int k = 0; k < 4; k++) {ev[k], en[k]} = '0;
		{out_q, err_q} = 2'b00;
		i_ctl.issue(2'h1, 8'h20);
		{ev[2], en[2]} = {16'h0001, 16'h0001};
		repeat (2) @(posedge clk_sys);
		#5 check_bit(request_bit, 1'b1);
		check_bit(oe_n, 1'b0);
		repeat (2) begin
			p_exp.push_back(8'h60);
			i_ctl.issue(2'h3, 8'h00);
			check_bit(summary_bit, 1'b1);
			check_bit(request_bit, 1'b0);
			@(posedge clk_sys);
			#5 check_bit(request_bit, 1'b1);
		end
		ev[2] = 16'h0000;
		q_exp.push_back(8'h00);
		i_ctl.issue(2'h2, 8'h00);
		i_ctl.issue(2'h1, 8'h00);
		check(srm, 8'h00);
		for (int i = 0; i < 20 && (q_exp.size() || p_exp.size()); i++) @(posedge clk_sys);
		if (q_exp.size() || p_exp.size()) begin
			num_errors++;
			$display("unexpected at %0t: results missing", $time);
		end
		test_done();
	end
endmodule // status_byte_srq_tb
